// >>> design/wrt_pkg.sv
/*
 * Shared constants of the watchdog refresh timer: register map, field
 * positions, reset values and timing counts.
 * Assumes a 50 MHz aclk and an AXI4-Lite register bus with 32-bit data.
 */
package wrt_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets.
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_IE_MAIN = 8'h04;
   localparam logic [7:0] OFS_IE_SECOND = 8'h08;
   localparam logic [7:0] OFS_RELOAD = 8'h0c;
   localparam logic [7:0] OFS_COUNT = 8'h10;
   localparam logic [7:0] OFS_PRIO_FIRST = 8'h14;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

   // ---------------------------------------------------------------
   // Field positions and values.
   // ---------------------------------------------------------------
   localparam int ARM_BIT = 6;
   localparam int FIRE_BIT = 6;
   localparam int EXPIRY_FLAG_BIT = 6;
   localparam int SEL16_BIT = 7;
   localparam int CTRL_STRAP_BIT = 1;
   localparam int CTRL_EXPIRY_BIT = 2;
   localparam logic [15:0] CNT_EXPIRY = 16'h7cff;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [7:0] REG8_RESET = 8'h00;
   localparam logic [3:0] IRQ_RESET = 4'h0;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // Interrupt status bit positions.
   localparam int EV_EXPIRY = 0;
   localparam int EV_REFRESH = 1;
   localparam int EV_ARM_TIMEOUT = 2;
   localparam int EV_START = 3;

   // ---------------------------------------------------------------
   // Divider ratios and timing counts in aclk cycles.
   // ---------------------------------------------------------------
   localparam int MC_DIV = 12;
   localparam int PRE_A_DIV = 2;
   localparam int PRE_B_DIV = 16;
   localparam int ARM_WINDOW = 12;
   localparam int RST_QUAL = 2;

   // ---------------------------------------------------------------
   // Bus answers.
   // ---------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [3:0] {
      SEL_CTRL, SEL_IE_MAIN, SEL_IE_SECOND, SEL_RELOAD,
      SEL_COUNT, SEL_PRIO, SEL_STAT, SEL_MASK, SEL_NONE
   } wrt_sel_e;
endpackage : wrt_pkg

// >>> design/wrt_sync.sv
/*
 * Two flip-flop synchroniser for pin levels.
 * Assumes the inputs are levels that hold for several aclk cycles.
 */
`timescale 1ns/1ps
module wrt_sync #(
   parameter int W = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   initial
   begin
      if (W < 1) $error("wrt_sync width must be at least one");
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_r <= '0;
         q <= '0;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : wrt_sync

// >>> design/wrt_prescaler.sv
/*
 * Clock path of the watchdog: machine-cycle divider, divide-by-2 stage and
 * the selectable divide-by-16 stage, giving one step pulse per count.
 * Assumes run and sel16 come from logic on aclk.
 */
`timescale 1ns/1ps
module wrt_prescaler
   import wrt_pkg::*;
#(
   parameter int MCD = MC_DIV,
   parameter int PAD = PRE_A_DIV,
   parameter int PBD = PRE_B_DIV
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic sel16,
   output logic step
);
   localparam int MW = $clog2(MCD);
   localparam int AW = $clog2(PAD);
   localparam int BW = $clog2(PBD);
   localparam logic [MW-1:0] MC_LAST = MW'(MCD - 1);
   localparam logic [AW-1:0] A_LAST = AW'(PAD - 1);
   localparam logic [BW-1:0] B_LAST = BW'(PBD - 1);

   logic [MW-1:0] mc_r;
   logic [AW-1:0] pa_r;
   logic [BW-1:0] pb_r;
   wire mc_tick = (mc_r == MC_LAST);
   wire pa_tick = mc_tick && (pa_r == A_LAST);
   wire pb_tick = pa_tick && (pb_r == B_LAST);

   initial
   begin
      if (MCD < 2 || PAD < 2 || PBD < 2) $error("wrt_prescaler ratios must exceed one");
   end

   // Machine tick, then divide by 2, then divide by 16 when selected.
   assign step = sel16 ? pb_tick : pa_tick;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || !run)
      begin
         mc_r <= '0;
         pa_r <= '0;
         pb_r <= '0;
      end
      else
      begin
         mc_r <= mc_tick ? '0 : mc_r + 1'b1;
         if (mc_tick) pa_r <= (pa_r == A_LAST) ? '0 : pa_r + 1'b1;
         if (pa_tick) pb_r <= (pb_r == B_LAST) ? '0 : pb_r + 1'b1;
      end
   end
endmodule : wrt_prescaler

// >>> design/wrt_watchdog.sv
/*
 * Watchdog refresh timer with AXI4-Lite register access, internal reset
 * generation and a masked level interrupt.
 * Assumes a 50 MHz aclk, a synchronous active-low aresetn, and that the
 * reset and strap pins are asynchronous levels.
 */
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module wrt_watchdog
   import wrt_pkg::*;
#(
   parameter int AW = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_reset_pin,
   input wire logic autostart_strap,
   output logic wdt_expired,
   output logic sys_reset,
   output logic irq
);
   import wrt_pkg::*;

   initial
   begin
      if (AW < 8) $error("wrt_watchdog address width must be at least 8");
   end

   // ---------------------------------------------------------------
   // Address decode.
   // ---------------------------------------------------------------
   function automatic wrt_sel_e sel_of(input logic [AW-1:0] a);
      wrt_sel_e s;
      s = SEL_NONE;
      if ((a >> 8) == '0)
      begin
         unique case (a[7:0])
            OFS_CTRL: s = SEL_CTRL;
            OFS_IE_MAIN: s = SEL_IE_MAIN;
            OFS_IE_SECOND: s = SEL_IE_SECOND;
            OFS_RELOAD: s = SEL_RELOAD;
            OFS_COUNT: s = SEL_COUNT;
            OFS_PRIO_FIRST: s = SEL_PRIO;
            OFS_IRQ_STAT: s = SEL_STAT;
            OFS_IRQ_MASK: s = SEL_MASK;
            default: s = SEL_NONE;
         endcase
      end
      return s;
   endfunction : sel_of

   // ---------------------------------------------------------------
   // Pin synchronisers.
   // ---------------------------------------------------------------
   logic [1:0] pins_s;
   wrt_sync #(.W(2)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({autostart_strap, ext_reset_pin}),
      .q(pins_s)
   );
   wire ext_rst_s = pins_s[0];
   wire strap_s = pins_s[1];

   // ---------------------------------------------------------------
   // State.
   // ---------------------------------------------------------------
   logic [15:0] cnt_r;
   logic [7:0] ie_main_r;
   logic [7:0] ie_second_r;
   logic [7:0] reload_r;
   logic [7:0] prio_r;
   logic [3:0] stat_r;
   logic [3:0] mask_r;
   logic started_r;
   logic strap_seen_r;
   logic [3:0] arm_cnt_r;
   logic req_d_r;
   logic rst_int_r;
   logic expired_d_r;

   // ---------------------------------------------------------------
   // Bus write side.
   // ---------------------------------------------------------------
   logic aw_hold_r;
   logic w_hold_r;
   logic [AW-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic wstrb0_r;
   logic bvalid_r;
   logic [1:0] bresp_r;

   assign s_axi_awready = !aw_hold_r && !bvalid_r;
   assign s_axi_wready = !w_hold_r && !bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire aw_have = aw_hold_r || aw_take;
   wire w_have = w_hold_r || w_take;
   wire wr_go = aw_have && w_have && !bvalid_r;
   wire [AW-1:0] wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr;
   wire [31:0] wr_data = w_hold_r ? wdata_r : s_axi_wdata;
   wire wr_lane0 = w_hold_r ? wstrb0_r : s_axi_wstrb[0];
   wrt_sel_e wr_sel;
   assign wr_sel = sel_of(wr_addr);
   wire wr_en = wr_go && wr_lane0;
   wire [7:0] wr_byte = wr_data[7:0];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= RD_ZERO;
         wstrb0_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end
      else
      begin
         if (aw_take) awaddr_r <= s_axi_awaddr;
         if (w_take) wdata_r <= s_axi_wdata;
         if (w_take) wstrb0_r <= s_axi_wstrb[0];
         aw_hold_r <= aw_have && !wr_go;
         w_hold_r <= w_have && !wr_go;
         if (wr_go)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (s_axi_bready) bvalid_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Bus read side.
   // ---------------------------------------------------------------
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;

   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   wire rd_go = s_axi_arvalid && !rvalid_r;
   wrt_sel_e rd_sel;
   assign rd_sel = sel_of(s_axi_araddr);
   wire stat_rd = rd_go && (rd_sel == SEL_STAT);

   // Fire bit reads back as started status.
   wire [7:0] ie_second_rd = {ie_second_r[7], started_r, ie_second_r[5:0]};
   wire [7:0] ctrl_rd = {5'h00, wdt_expired, strap_seen_r, started_r};
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = RD_ZERO;
      unique case (rd_sel)
         SEL_CTRL: rd_mux[7:0] = ctrl_rd;
         SEL_IE_MAIN: rd_mux[7:0] = ie_main_r;
         SEL_IE_SECOND: rd_mux[7:0] = ie_second_rd;
         SEL_RELOAD: rd_mux[7:0] = reload_r;
         SEL_COUNT: rd_mux[15:0] = cnt_r;
         SEL_PRIO: rd_mux[7:0] = prio_r;
         SEL_STAT: rd_mux[3:0] = stat_r;
         SEL_MASK: rd_mux[3:0] = mask_r;
         SEL_NONE: rd_mux = RD_ZERO;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= RD_ZERO;
         rresp_r <= RESP_OKAY;
      end
      else if (rd_go)
      begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_rready) rvalid_r <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Watchdog control.
   // ---------------------------------------------------------------
   wire arm_wr = wr_en && (wr_sel == SEL_IE_MAIN);
   wire fire_wr = wr_en && (wr_sel == SEL_IE_SECOND) && wr_byte[FIRE_BIT];
   wire arm_now = ie_main_r[ARM_BIT];
   wire refresh = fire_wr && arm_now && started_r;
   wire arm_timeout = arm_now && (arm_cnt_r == 4'(ARM_WINDOW - 1)) && !refresh && !arm_wr;
   wire start_req = fire_wr && !started_r;
   wire step;

   wrt_prescaler u_pre (
      .aclk(aclk),
      .aresetn(aresetn && !rst_int_r),
      .run(started_r),
      .sel16(reload_r[SEL16_BIT]),
      .step(step)
   );

   // Expiry is a pure decode of the counter and started_r, so any change clears it.
   assign wdt_expired = started_r && (cnt_r == CNT_EXPIRY);

   // External reset and internal reset both clear the watchdog.
   wire wdt_clr = !aresetn || rst_int_r;

   always_ff @(posedge aclk)
   begin
      if (wdt_clr)
      begin
         started_r <= !aresetn ? 1'b0 : strap_s;
         strap_seen_r <= !aresetn ? 1'b0 : strap_s;
         cnt_r <= CNT_RESET;
         reload_r <= REG8_RESET;
         arm_cnt_r <= '0;
      end
      else
      begin
         if (start_req) started_r <= 1'b1;
         if (wr_en && wr_sel == SEL_RELOAD) reload_r <= wr_byte;
         if (refresh) cnt_r <= {1'b0, reload_r[6:0], 8'h00};
         else if (started_r && step) cnt_r <= cnt_r + 16'h0001;
         if (!arm_now || arm_wr) arm_cnt_r <= '0;
         else arm_cnt_r <= arm_cnt_r + 4'h1;
      end
   end

   // Main enable register; its bit 6 is the arm flag.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ie_main_r <= REG8_RESET;
      end
      else
      begin
         if (arm_wr) ie_main_r <= wr_byte;
         if (rst_int_r || refresh || arm_timeout) ie_main_r[ARM_BIT] <= 1'b0;
      end
   end

   // Second enable register; bit 6 holds nothing, writes only fire.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ie_second_r <= REG8_RESET;
      end
      else if (wr_en && wr_sel == SEL_IE_SECOND)
      begin
         ie_second_r <= wr_byte & ~(8'h01 << FIRE_BIT);
      end
   end

   // Expiry flag in the priority register, set wins over a write.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prio_r <= REG8_RESET;
      end
      else
      begin
         if (wr_en && wr_sel == SEL_PRIO) prio_r <= wr_byte;
         if (wdt_expired) prio_r[EXPIRY_FLAG_BIT] <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Internal reset: request or pin held for two cycles.
   // ---------------------------------------------------------------
   wire rst_cause = ext_rst_s || wdt_expired;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         req_d_r <= 1'b0;
         rst_int_r <= 1'b0;
      end
      else
      begin
         req_d_r <= rst_cause;
         rst_int_r <= rst_cause && req_d_r;
      end
   end

   assign sys_reset = rst_int_r;

   // ---------------------------------------------------------------
   // Interrupts: sticky status, cleared by read, masked to one level.
   // ---------------------------------------------------------------
   logic [3:0] ev;
   always_comb
   begin
      ev = IRQ_RESET;
      ev[EV_EXPIRY] = wdt_expired && !expired_d_r;
      ev[EV_REFRESH] = refresh;
      ev[EV_ARM_TIMEOUT] = arm_timeout;
      ev[EV_START] = start_req;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         stat_r <= IRQ_RESET;
         mask_r <= IRQ_RESET;
         expired_d_r <= 1'b0;
      end
      else
      begin
         expired_d_r <= wdt_expired;
         stat_r <= (stat_rd ? IRQ_RESET : stat_r) | ev;
         if (wr_en && wr_sel == SEL_MASK) mask_r <= wr_byte[3:0];
      end
   end

   assign irq = |(stat_r & mask_r);
endmodule : wrt_watchdog

// >>> verif/wrt_watchdog_asserts.sv
/*
 * Port checker of the watchdog: bus handshakes, expiry and reset timing.
 * Assumes it is bound into wrt_watchdog and sees its ports by name.
 */
`timescale 1ns/1ps
module wrt_watchdog_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_reset_pin,
   input wire logic wdt_expired,
   input wire logic sys_reset,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ---------------------------------------------------------------
   // Bus handshakes.
   // ---------------------------------------------------------------
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped early");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped or changed");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |=> s_axi_bvalid)
      else $error("write answer late");
   // ---------------------------------------------------------------
   // Expiry and reset.
   // ---------------------------------------------------------------
   AST_EXP_SEQ: assert property ($rose(wdt_expired) |->
      wdt_expired ##1 wdt_expired ##[1:2] sys_reset)
      else $error("expiry did not lead to reset");
   AST_EXP_CLR: assert property (sys_reset |=> !wdt_expired)
      else $error("expiry not cleared by reset");
   AST_EXT_RST: assert property (ext_reset_pin [*5] |-> ##[0:2] sys_reset)
      else $error("reset pin ignored");
   AST_RST_CAUSE: assert property ($rose(sys_reset) |->
      $past(wdt_expired) || $past(ext_reset_pin, 3))
      else $error("reset without cause");
   CV_EXP: cover property (wdt_expired);
   CV_RST: cover property (sys_reset);
   CV_IRQ: cover property (irq);
   CV_RD: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : wrt_watchdog_asserts
bind wrt_watchdog wrt_watchdog_asserts u_chk (.*);

// >>> verif/wrt_cpu_model.sv
/*
 * CPU side model: issues register writes and reads on AXI4-Lite.
 * Assumes the testbench calls wr and rd one at a time.
 */
`timescale 1ns/1ps
module wrt_cpu_model (
   input wire logic aclk,
   output logic [7:0] s_axi_awaddr = 8'h00,
   output logic s_axi_awvalid = 1'b0,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata = 32'h0,
   output logic [3:0] s_axi_wstrb = 4'h0,
   output logic s_axi_wvalid = 1'b0,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready = 1'b0,
   output logic [7:0] s_axi_araddr = 8'h00,
   output logic s_axi_arvalid = 1'b0,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready = 1'b0
);
   int seed = 24;

   // Writes one byte; the answer may be accepted promptly or slowly.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'($random(seed));
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
   endtask : wr

   // Reads one word; the answer may be accepted promptly or slowly.
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'($random(seed));
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : wrt_cpu_model

// >>> verif/watchdog_refresh_timer_tb_top.sv
/*
 * Self-checking testbench of the watchdog refresh timer.
 * Assumes wrt_watchdog with its default address width and the CPU model.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module watchdog_refresh_timer_tb_top;
   import wrt_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ext_reset_pin = 1'b0;
   logic autostart_strap = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic wdt_expired, sys_reset, irq;
   int err_count = 0;
   int comparisons = 0;
   int seed = 24;
   int cyc = 0;
   int n;
   logic saw_rst = 1'b0;
   logic [65:0] exp_q[$];
   logic [65:0] e;
   logic [7:0] d;
   logic [7:0] v[5];
   logic [7:0] offs[5] = '{OFS_RELOAD, OFS_IE_MAIN, OFS_IE_SECOND, OFS_PRIO_FIRST, OFS_IRQ_MASK};
   logic [7:0] msk[5] = '{8'hff, 8'hbf, 8'hbf, 8'hbf, 8'h0f};

   always #10 aclk = ~aclk;

   wrt_watchdog dut (.*);
   wrt_cpu_model cpu (.*);

   // ---------------------------------------------------------------
   // Driver tasks: note the expected answer, then run the bus cycle.
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] dd, input logic [1:0] r = RESP_OKAY);
      exp_q.push_back({32'h0, r, 32'h0});
      cpu.wr(a, dd);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic [31:0] m = 32'hffffffff, input logic [1:0] r = RESP_OKAY);
      exp_q.push_back({m, r, x});
      cpu.rd(a);
   endtask : rd

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   // ---------------------------------------------------------------
   // Monitor: compares each bus answer with the oldest note.
   // ---------------------------------------------------------------
   always @(posedge aclk)
   begin
      cyc++;
      if (sys_reset === 1'b1) saw_rst <= 1'b1;
      if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))
      begin
         e = exp_q.pop_front();
         if (s_axi_rvalid)
            `CHK("read", {e[33:32], e[31:0] & e[65:34]}, {s_axi_rresp, s_axi_rdata & e[65:34]})
         else
            `CHK("bresp", e[33:32], s_axi_bresp)
      end
      if (cyc == 20000)
      begin
         err_count++;
         complete_run();
      end
   end

   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0);
      rd(8'h20, 32'h0, 32'hffffffff, RESP_SLVERR);
      wr(8'h20, 8'hff, RESP_SLVERR);
      wr(OFS_COUNT, 8'h55);
      rd(OFS_COUNT, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         d = 8'($random(seed)) & msk[i];
         v[i] = d;
         wr(offs[i], d);
         rd(offs[i], {24'h0, d});
      end
      wr(OFS_IRQ_MASK, 8'h0f);
      wr(OFS_IE_SECOND, 8'h40);
      rd(OFS_IE_SECOND, 32'h40);
      rd(OFS_CTRL, 32'h1);
      `CHK("irq", 1'b1, irq)
      rd(OFS_IRQ_STAT, 32'h8);
      @(posedge aclk);
      `CHK("irq", 1'b0, irq)
      wr(OFS_IE_MAIN, 8'h40);
      rd(OFS_IE_MAIN, 32'h40);
      repeat (12) @(posedge aclk);
      rd(OFS_IE_MAIN, 32'h0);
      wr(OFS_IE_SECOND, 8'h40);
      rd(OFS_IRQ_STAT, 32'h4);
      wr(OFS_RELOAD, 8'hfc);
      wr(OFS_IE_MAIN, 8'h40);
      wr(OFS_IE_SECOND, 8'h40);
      rd(OFS_IE_MAIN, 32'h0);
      repeat (200) @(posedge aclk);
      rd(OFS_COUNT, 32'h7c00, 32'hfffffffe);
      rd(OFS_IRQ_STAT, 32'h2);
      wr(OFS_RELOAD, 8'h7c);
      wr(OFS_IE_MAIN, 8'h40);
      wr(OFS_IE_SECOND, 8'h40);
      n = 0;
      saw_rst = 1'b0;
      while (wdt_expired !== 1'b1 && n < 7000)
      begin
         @(posedge aclk);
         n++;
      end
      `CHK("expiry cycles", 1'b1, n > 6000 && n <= 6120)
      repeat (10) @(posedge aclk);
      `CHK("reset request", 1'b1, saw_rst)
      `CHK("irq", 1'b1, irq)
      rd(OFS_PRIO_FIRST, {24'h0, v[3] | 8'h40});
      rd(OFS_IRQ_STAT, 32'h3);
      rd(OFS_RELOAD, 32'h0);
      repeat (50) @(posedge aclk);
      rd(OFS_CTRL, 32'h0);
      rd(OFS_COUNT, 32'h0);
      saw_rst = 1'b0;
      autostart_strap <= 1'b1;
      ext_reset_pin <= 1'b1;
      repeat (8) @(posedge aclk);
      ext_reset_pin <= 1'b0;
      repeat (6) @(posedge aclk);
      autostart_strap <= 1'b0;
      `CHK("pin reset", 1'b1, saw_rst)
      wr(OFS_IE_SECOND, 8'h00);
      rd(OFS_CTRL, 32'h1, 32'hfffffffd);
      rd(OFS_COUNT, 32'h0, 32'hffffff00);
      complete_run();
   end
endmodule : watchdog_refresh_timer_tb_top
